/* File: src/ucb_uart_top.sv */
// Purpose: uart control registers, transmitter, receiver and pin steering
// Assumes: APB master per protocol; SHARED_I and UART_CLK_OFF are asynchronous
// Notes: zero wait state slave; read data is captured in the setup cycle
`timescale 1ns/1ps
module ucb_uart_top (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic UART_CLK_OFF,
  input wire logic SHARED_I,
  output logic TX_O,
  output logic TX_OE,
  output logic SHARED_O,
  output logic SHARED_OE,
  output logic SHARED_IRQ
);
  // ********************
  // input synchronisers
  // ********************
  logic [1:0] sync_q;
  logic rx_in;
  logic clk_off;
  logic rx_prev_r;

  ucb_sync2 #(.WIDTH(2), .INIT(2'h1)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .d({UART_CLK_OFF, SHARED_I}),
    .q(sync_q)
  );
  assign rx_in = sync_q[0];
  assign clk_off = sync_q[1];

  // ********************
  // bus decode
  // ********************
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic swm_r;
  logic [7:0] brg_r;
  logic [8:0] txhold_r;
  logic txfull_r;
  logic [7:0] rxdata_r;
  logic rx8_r;
  logic rxav_r;
  logic oerr_r;
  logic wake_r;
  logic armed_r;
  logic [7:0] ctrl2_nxt;

  wire setup = PSEL & ~PENABLE;
  wire acc = PSEL & PENABLE;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  wire hit_ctrl1 = (PADDR == ucb_pkg::ADDR_CTRL1);
  wire hit_stat = (PADDR == ucb_pkg::ADDR_STAT);
  wire hit_ctrl2 = (PADDR == ucb_pkg::ADDR_CTRL2);
  wire hit_swc = (PADDR == ucb_pkg::ADDR_SWC);
  wire hit_data = (PADDR == ucb_pkg::ADDR_DATA);
  wire hit_brg = (PADDR == ucb_pkg::ADDR_BRG);
  wire mapped = hit_ctrl1 | hit_stat | hit_ctrl2 | hit_swc | hit_data | hit_brg;
  wire wr_ctrl1 = wr & hit_ctrl1;
  wire wr_stat = wr & hit_stat;
  wire wr_ctrl2 = wr & hit_ctrl2;
  wire wr_data = wr & hit_data;
  wire rd_stat = rd & hit_stat;
  wire rd_data = rd & hit_data;

  assign PREADY = 1'b1;
  assign PSLVERR = acc & ~mapped;

  // ********************
  // mode and enables
  // ********************
  wire uen = ctrl1_r[ucb_pkg::B_UEN];
  wire nine = ctrl1_r[ucb_pkg::B_NINE];
  wire on = uen & ctrl1_r[ucb_pkg::B_MODE];
  wire tx_on = on & ctrl2_r[ucb_pkg::B_TXEN];
  wire rx_on = on & ctrl2_r[ucb_pkg::B_RXEN];
  // single wire: the transmitter only gets the shared pin when the receiver is off
  wire sw_tx = swm_r & ctrl2_r[ucb_pkg::B_TXEN] & ~ctrl2_r[ucb_pkg::B_RXEN];
  wire [3:0] last_bit = nine ? ucb_pkg::BITS9_LAST : ucb_pkg::BITS8_LAST;
  wire uen_off = wr_ctrl1 & ~PWDATA[ucb_pkg::B_UEN];

  always_comb begin
    ctrl2_nxt = wr_ctrl2 ? PWDATA[7:0] : ctrl2_r;
    // disabling the uart drops both direction enables, other bits stay
    if (uen_off) begin
      ctrl2_nxt[ucb_pkg::B_TXEN] = 1'b0;
      ctrl2_nxt[ucb_pkg::B_RXEN] = 1'b0;
    end
  end

  // ********************
  // baud generator
  // ********************
  logic tick;

  ucb_baud_gen u_baud (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .run(on & ~clk_off),
    .hi_speed(ctrl2_r[ucb_pkg::B_BRGH]),
    .divisor(brg_r),
    .sample_tick(tick)
  );

  // ********************
  // transmitter
  // ********************
  ucb_pkg::ucb_tx_e tx_st_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic [3:0] tx_tick_r;
  logic tx_stop2_r;
  logic tx_line_r;

  wire tx_load = (tx_st_r == ucb_pkg::TX_IDLE) & txfull_r;
  wire tx_bit_end = tick & (tx_tick_r == ucb_pkg::OVS_LAST);
  wire tx_empty = ~txfull_r;
  wire tx_idle = tx_empty & (tx_st_r == ucb_pkg::TX_IDLE);

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN || !tx_on) begin
      tx_st_r <= ucb_pkg::TX_IDLE;
      tx_sh_r <= 9'h000;
      tx_bit_r <= 4'h0;
      tx_tick_r <= 4'h0;
      tx_stop2_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      if (tick) begin
        tx_tick_r <= tx_tick_r + 4'h1;
      end
      case (tx_st_r)
        ucb_pkg::TX_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_load) begin
            tx_sh_r <= txhold_r;
            tx_tick_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_stop2_r <= 1'b0;
            tx_line_r <= 1'b0;
            tx_st_r <= ucb_pkg::TX_START;
          end
        end
        ucb_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_line_r <= tx_sh_r[0];
            tx_st_r <= ucb_pkg::TX_DATA;
          end
        end
        ucb_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit_r == last_bit) begin
              tx_line_r <= 1'b1;
              tx_st_r <= ucb_pkg::TX_STOP;
            end else begin
              tx_line_r <= tx_sh_r[1];
              tx_sh_r <= {1'b0, tx_sh_r[8:1]};
              tx_bit_r <= tx_bit_r + 4'h1;
            end
          end
        end
        ucb_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            if (ctrl1_r[ucb_pkg::B_STOP2] && !tx_stop2_r) begin
              tx_stop2_r <= 1'b1;
            end else begin
              tx_st_r <= ucb_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st_r <= ucb_pkg::TX_IDLE;
      endcase
    end
  end

  // holding register: a write in the load cycle refills it, so set wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      txhold_r <= 9'h000;
      txfull_r <= 1'b0;
    end else begin
      if (wr_data) begin
        txhold_r <= {ctrl1_r[ucb_pkg::B_TX8], PWDATA[7:0]};
      end
      if (!tx_on) begin
        txfull_r <= 1'b0;
      end else if (wr_data) begin
        txfull_r <= 1'b1;
      end else if (tx_load) begin
        txfull_r <= 1'b0;
      end
    end
  end

  // ********************
  // receiver
  // ********************
  ucb_pkg::ucb_rx_e rx_st_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_bit_r;
  logic [3:0] rx_tick_r;

  wire rx_bit_end = tick & (rx_tick_r == ucb_pkg::OVS_LAST);
  wire rx_done = (rx_st_r == ucb_pkg::RX_STOP) & rx_bit_end;
  wire [8:0] rx_word = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
  wire rx_addr_bit = nine ? rx_word[8] : rx_word[7];
  wire rx_keep = ~ctrl2_r[ucb_pkg::B_ADDEN] | rx_addr_bit;
  wire rx_deliver = rx_done & rx_keep;
  wire rx_idle = (rx_st_r == ucb_pkg::RX_IDLE);

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN || !rx_on) begin
      rx_st_r <= ucb_pkg::RX_IDLE;
      rx_sh_r <= 9'h000;
      rx_bit_r <= 4'h0;
      rx_tick_r <= 4'h0;
    end else if (tick) begin
      rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_st_r)
        ucb_pkg::RX_IDLE: begin
          rx_tick_r <= 4'h0;
          if (!rx_in) begin
            rx_st_r <= ucb_pkg::RX_START;
          end
        end
        ucb_pkg::RX_START: begin
          // re-check the start bit at its middle to reject glitches
          if (rx_tick_r == ucb_pkg::OVS_MID) begin
            rx_tick_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_st_r <= rx_in ? ucb_pkg::RX_IDLE : ucb_pkg::RX_DATA;
          end
        end
        ucb_pkg::RX_DATA: begin
          if (rx_tick_r == ucb_pkg::OVS_LAST) begin
            rx_sh_r <= {rx_in, rx_sh_r[8:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == last_bit) begin
              rx_st_r <= ucb_pkg::RX_STOP;
            end
          end
        end
        ucb_pkg::RX_STOP: begin
          // only one stop bit is sampled; its level is not judged here
          if (rx_tick_r == ucb_pkg::OVS_LAST) begin
            rx_st_r <= ucb_pkg::RX_IDLE;
          end
        end
        default: rx_st_r <= ucb_pkg::RX_IDLE;
      endcase
    end
  end

  // ********************
  // receive flags
  // ********************
  // status read arms the clear, the following data read performs it
  wire rx_clr = rd_data & armed_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rxdata_r <= 8'h00;
      rx8_r <= 1'b0;
      rxav_r <= 1'b0;
      oerr_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        armed_r <= 1'b1;
      end else if (rd_data) begin
        armed_r <= 1'b0;
      end
      if (!rx_on) begin
        rxav_r <= 1'b0;
        oerr_r <= 1'b0;
      end else if (rx_deliver && rxav_r && !rx_clr) begin
        oerr_r <= 1'b1; // unread byte kept, new one lost
      end else if (rx_deliver) begin
        rxdata_r <= rx_word[7:0];
        rx8_r <= rx_word[8];
        rxav_r <= 1'b1;
        if (rx_clr) begin
          oerr_r <= 1'b0;
        end
      end else if (rx_clr) begin
        rxav_r <= 1'b0;
        oerr_r <= 1'b0;
      end
    end
  end

  // ********************
  // pin wake-up
  // ********************
  wire wake_set = clk_off & ctrl2_r[ucb_pkg::B_WAKE] & rx_prev_r & ~rx_in;
  wire wake_clr = wr_stat & PWDATA[ucb_pkg::B_WAKEF];

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rx_prev_r <= 1'b1;
      wake_r <= 1'b0;
    end else begin
      rx_prev_r <= rx_in;
      if (wake_set) begin
        wake_r <= 1'b1;
      end else if (wake_clr) begin
        wake_r <= 1'b0;
      end
    end
  end

  // ********************
  // control registers
  // ********************
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      ctrl1_r <= ucb_pkg::CTRL_RST;
      ctrl2_r <= ucb_pkg::CTRL_RST;
      swm_r <= 1'b0;
      brg_r <= ucb_pkg::BRG_RST;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_r <= PWDATA[7:0];
      end
      ctrl2_r <= ctrl2_nxt;
      if (wr & hit_swc) begin
        swm_r <= PWDATA[ucb_pkg::B_SWM];
      end
      if (wr & hit_brg) begin
        brg_r <= PWDATA[7:0];
      end
    end
  end

  // ********************
  // read path and outputs
  // ********************
  wire [7:0] ctrl1_rd = {ctrl1_r[7:5], 1'b0, ctrl1_r[ucb_pkg::B_STOP2], 1'b0, rx8_r, 1'b0};
  wire [7:0] stat_rd = {2'h0, oerr_r, wake_r, rx_idle, rxav_r, tx_idle, tx_empty};
  wire [7:0] swc_rd = {7'h00, swm_r};
  wire [7:0] rd_mux = hit_ctrl1 ? ctrl1_rd :
                      hit_stat ? stat_rd :
                      hit_ctrl2 ? ctrl2_r :
                      hit_swc ? swc_rd :
                      hit_data ? rxdata_r :
                      hit_brg ? brg_r : 8'h00;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (setup) begin
      PRDATA <= {24'h000000, rd_mux};
    end
  end

  assign TX_O = tx_line_r;
  assign TX_OE = tx_on & ~swm_r;
  assign SHARED_O = tx_line_r;
  assign SHARED_OE = tx_on & sw_tx;
  // wake request shares the receive interrupt enable; software restarts the clock itself
  assign SHARED_IRQ = (ctrl2_r[ucb_pkg::B_RIE] & (oerr_r | rxav_r | wake_r)) |
                      (ctrl2_r[ucb_pkg::B_TIIE] & tx_idle) |
                      (ctrl2_r[ucb_pkg::B_TEIE] & tx_empty);
endmodule : ucb_uart_top

/* File: src/ucb_pkg.sv */
// Purpose: shared constants for the UART control and baud generator block
// Assumes: APB register bus, 32-bit data, one register per aligned word
// Notes: register bytes sit in the low lanes, upper bits read as zero
//
// Summary of operation
// - clearing tx_enable aborts transmission, empties transmit buffer, floats transmit pin
// - transmit pin driven only with tx_enable, uart_mode_select, uart_enable all set
// - clearing rx_enable aborts reception, empties receive buffer, releases receive pin
// - receiver uses its pin only with rx_enable, uart_mode_select, uart_enable set
// - baud timing comes from a free-running 8-bit counter set by divisor and speed
// - bit rate is clock / (64*(N+1)) low speed, clock / (16*(N+1)) high speed
// - divisor N is the unsigned 8-bit baud_divisor value, 0 to 255
// - with address detect, top bit one marks an address and may raise receive interrupt
// - with address detect, a word whose address bit is zero is dropped silently
// - clock stopped and pin_wake_enable set: receive pin falling edge raises wake request
// - no wake request while the uart clock runs or pin_wake_enable is zero
// - rx_irq_enable gates overrun_flag and rx_data_available onto shared_irq_request
// - tx_idle_irq_enable gates tx_idle_flag onto shared_irq_request
// - tx_empty_irq_enable gates tx_empty_flag onto shared_irq_request
// - single_wire_select zero: shared pin is receive only; one: shared by enables
// - single wire with both enables high: shared pin is receiver input only
// - one 8-bit data register: writes go to transmit, reads return received byte
// - upper seven bits of single wire control register read as zero
// - frame: start, 8 or 9 data bits lsb first, 1 or 2 stop bits; receiver times one, level unchecked
// - transmit pin rests high while nothing is sent
package ucb_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_SWC = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_BRG = 8'h14;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BRG_RST = 8'h00;

  // ********************
  // field positions
  // ********************
  localparam int B_UEN = 7;
  localparam int B_NINE = 6;
  localparam int B_MODE = 5;
  localparam int B_STOP2 = 3;
  localparam int B_RX8 = 1;
  localparam int B_TX8 = 0;
  localparam int B_TXEN = 7;
  localparam int B_RXEN = 6;
  localparam int B_BRGH = 5;
  localparam int B_ADDEN = 4;
  localparam int B_WAKE = 3;
  localparam int B_RIE = 2;
  localparam int B_TIIE = 1;
  localparam int B_TEIE = 0;
  localparam int B_OERR = 5;
  localparam int B_WAKEF = 4;
  localparam int B_RIDLE = 3;
  localparam int B_RXAV = 2;
  localparam int B_TIDLE = 1;
  localparam int B_TXE = 0;
  localparam int B_SWM = 0;

  // ********************
  // timing
  // ********************
  // sixteen sample ticks per bit; low speed adds a divide by four after the divisor counter
  localparam logic [1:0] PRE_LO = 2'h3;
  localparam logic [1:0] PRE_HI = 2'h0;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS8_LAST = 4'h7;
  localparam logic [3:0] BITS9_LAST = 4'h8;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ucb_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucb_rx_e;
endpackage : ucb_pkg

/* File: src/ucb_sync2.sv */
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: inputs change slowly compared to the clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module ucb_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : ucb_sync2

/* File: src/ucb_baud_gen.sv */
// Purpose: baud generator giving sixteen sample ticks per bit
// Assumes: divisor may change at any time, it is picked up at the next reload
// Notes: one tick every (N+1) clocks high speed, every 4*(N+1) clocks low speed
`timescale 1ns/1ps
module ucb_baud_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic hi_speed,
  input wire logic [7:0] divisor,
  output logic sample_tick
);
  logic [7:0] cnt_r;
  logic [1:0] pre_r;
  wire reload = (cnt_r == 8'h00);
  wire [1:0] pre_last = hi_speed ? ucb_pkg::PRE_HI : ucb_pkg::PRE_LO;
  wire pre_wrap = (pre_r >= pre_last);

  assign sample_tick = run & reload & pre_wrap;

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_r <= 8'h00;
      pre_r <= 2'h0;
    end else begin
      cnt_r <= reload ? divisor : cnt_r - 8'h01;
      if (reload) begin
        pre_r <= pre_wrap ? 2'h0 : pre_r + 2'h1;
      end
    end
  end
endmodule : ucb_baud_gen

/* File: testbench/ucb_uart_asserts.sv */
// Purpose: port level checks for ucb_uart_top
// Assumes: control bits are shadowed from apb writes
// Notes: bound into every instance of the top
`timescale 1ns/1ps
module ucb_uart_asserts (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TX_O,
  input wire logic TX_OE,
  input wire logic SHARED_OE,
  input wire logic SHARED_IRQ
);
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  logic swm_r;
  wire wr = PSEL && PENABLE && PWRITE;
  wire tx_on = c1_r[7] && c1_r[5] && c2_r[7];
  wire unmapped = PADDR > ucb_pkg::ADDR_BRG || PADDR[1:0] != 2'h0;
  wire sw_tx = tx_on && swm_r && !c2_r[6];
  // uart off clears both enables, so the shadow follows that too
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
      swm_r <= 1'b0;
    end else if (wr && PADDR == ucb_pkg::ADDR_CTRL1) begin
      c1_r <= PWDATA[7:0];
      c2_r[7:6] <= PWDATA[7] ? c2_r[7:6] : 2'h0;
    end else if (wr && PADDR == ucb_pkg::ADDR_CTRL2) begin
      c2_r <= PWDATA[7:0];
    end else if (wr && PADDR == ucb_pkg::ADDR_SWC) begin
      swm_r <= PWDATA[0];
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  a_ready_always: assert property (PREADY) else $error("pready low");
  a_err_unmapped: assert property (PSEL && PENABLE && unmapped |-> PSLVERR) else $error("pslverr missing");
  a_err_quiet: assert property (!(PSEL && PENABLE) || !unmapped |-> !PSLVERR) else $error("pslverr spurious");
  a_rd_upper: assert property (PRDATA[31:8] == 24'h000000) else $error("prdata upper set");
  // read data is loaded at the edge that ends setup, so it must hold from the access edge on
  a_rd_stands: assert property (PSEL && PENABLE |=> $stable(PRDATA)) else $error("prdata moved");
  a_tx_oe_gate: assert property (TX_OE == (tx_on && !swm_r)) else $error("tx_oe wrong");
  a_sw_oe_gate: assert property (SHARED_OE == sw_tx) else $error("shared_oe wrong");
  a_tx_rests: assert property (!tx_on ##1 !tx_on |-> TX_O) else $error("tx line low");
  a_irq_masked: assert property (c2_r[2:0] == 3'h0 |-> !SHARED_IRQ) else $error("irq on");
endmodule : ucb_uart_asserts
bind ucb_uart_top ucb_uart_asserts u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TX_O(TX_O), .TX_OE(TX_OE), .SHARED_OE(SHARED_OE), .SHARED_IRQ(SHARED_IRQ));

/* File: testbench/ucb_remote_node.sv */
// Purpose: remote serial node on the transmit and shared pins
// Assumes: bit length in core clocks is set by the bench
// Notes: frames are timed from the falling start edge
`timescale 1ns/1ps
module ucb_remote_node (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 64;
  logic [7:0] got_q[$];
  initial line_out = 1'b1;
  // bit centres only, so a start bit short by one tick still decodes
  initial begin : rx_loop
    logic [7:0] w;
    forever begin
      @(posedge clk iff !line_in);
      repeat (bit_clks / 2) @(posedge clk);
      if (!line_in) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_clks) @(posedge clk);
          w[i] = line_in;
        end
        repeat (bit_clks) @(posedge clk);
        got_q.push_back(w);
      end
    end
  end
  task automatic send(input logic [7:0] w);
    logic [9:0] f;
    f = {1'b1, w, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (bit_clks - 1) @(posedge clk);
    end
  endtask : send
endmodule : ucb_remote_node

/* File: testbench/tb.sv */
// Purpose: self-checking bench for ucb_uart_top
// Assumes: zero wait apb slave, remote node at the pins
// Notes: expected bytes are queued, data comes from xorshift
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic clk_off = 1'b0;
  logic [31:0] prd;
  logic prdy, perr, er, tx, txoe, sho, shoe, irq, node_o;
  logic [31:0] rd, r;
  logic [31:0] seed = 32'h00005EE1;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int samples_checked = 0;
  // floating pins read as pulled up
  wire line = txoe ? tx : (shoe ? sho : 1'b1);
  wire shared_in = shoe ? sho : node_o;
  always #12.5 clk = ~clk;
  ucb_uart_top dut (.CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .UART_CLK_OFF(clk_off), .SHARED_I(shared_in),
    .TX_O(tx), .TX_OE(txoe), .SHARED_O(sho), .SHARED_OE(shoe), .SHARED_IRQ(irq));
  ucb_remote_node node (.clk(clk), .line_in(line), .line_out(node_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_st(input int b);
    for (int i = 0; i < 20000; i++) begin
      apb(1'b0, ucb_pkg::ADDR_STAT, 8'h00);
      if (rd[b] === 1'b1) break;
    end
    chk("status flag", 1, rd[b]);
  endtask : wait_st
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin : watchdog
    repeat (90000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  // ****************
  // main sequence
  // ****************
  initial begin : main
    int n;
    seed = 32'd24289;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ucb_pkg::ADDR_CTRL2, 8'h00);
    chk("ctrl2 reset", 0, rd);
    apb(1'b1, ucb_pkg::ADDR_SWC, 8'hFF);
    apb(1'b0, ucb_pkg::ADDR_SWC, 8'h00);
    chk("swc", 1, rd);
    apb(1'b1, 8'h18, 8'h5A);
    chk("pslverr", 1, er);
    apb(1'b0, 8'h18, 8'h00);
    chk("unmapped", 0, rd);
    apb(1'b1, ucb_pkg::ADDR_SWC, 8'h00);
    $display("test registers done");
    apb(1'b1, ucb_pkg::ADDR_CTRL1, 8'hA8);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      n = (k == 3) ? 255 : int'(r[1:0]);
      apb(1'b1, ucb_pkg::ADDR_BRG, n[7:0]);
      apb(1'b1, ucb_pkg::ADDR_CTRL2, k[0] ? 8'hA0 : 8'h80);
      node.bit_clks = (k[0] ? 16 : 64) * (n + 1);
      repeat (k == 3 ? 1 : 2) begin
        r = rnd();
        exp_q.push_back(r[7:0]);
        apb(1'b1, ucb_pkg::ADDR_DATA, r[7:0]);
      end
      wait_st(ucb_pkg::B_TIDLE);
      chk("tx count", exp_q.size(), node.got_q.size());
      while (node.got_q.size() > 0 && exp_q.size() > 0) begin
        chk("tx byte", exp_q.pop_front(), node.got_q.pop_front());
      end
      exp_q.delete();
    end
    // the irq follows the control write only once that edge has settled
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h81);
    @(negedge clk);
    chk("empty irq", 1, irq);
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h82);
    @(negedge clk);
    chk("idle irq", 1, irq);
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h80);
    @(negedge clk);
    chk("irq masked", 0, irq);
    $display("test transmit done");
    apb(1'b1, ucb_pkg::ADDR_BRG, 8'h00);
    node.bit_clks = 64;
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h80);
    apb(1'b1, ucb_pkg::ADDR_DATA, 8'h00);
    repeat (200) @(posedge clk);
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h00);
    repeat (2) @(posedge clk);
    chk("tx oe", 0, txoe);
    chk("tx line", 1, tx);
    repeat (1000) @(posedge clk);
    node.got_q.delete();
    $display("test abort done");
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h44);
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      if (k == 2) apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h40);
      node.send(r[7:0]);
      wait_st(ucb_pkg::B_RXAV);
      chk("rx irq", k < 2, irq);
      apb(1'b0, ucb_pkg::ADDR_DATA, 8'h00);
      chk("rx byte", r[7:0], rd);
    end
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h54);
    node.send(r[7:0] & 8'h7F);
    repeat (200) @(posedge clk);
    apb(1'b0, ucb_pkg::ADDR_STAT, 8'h00);
    chk("addr drop", 0, rd[ucb_pkg::B_RXAV]);
    chk("addr irq", 0, irq);
    node.send(r[7:0] | 8'h80);
    wait_st(ucb_pkg::B_RXAV);
    chk("addr irq", 1, irq);
    apb(1'b0, ucb_pkg::ADDR_DATA, 8'h00);
    chk("addr byte", r[7:0] | 8'h80, rd);
    fork
      node.send(8'h55);
      begin
        repeat (300) @(posedge clk);
        apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h00);
      end
    join
    repeat (100) @(posedge clk);
    apb(1'b0, ucb_pkg::ADDR_STAT, 8'h00);
    chk("rx abort", 0, rd[ucb_pkg::B_RXAV]);
    $display("test receive done");
    for (int k = 0; k < 3; k++) begin
      clk_off <= k > 0;
      apb(1'b1, ucb_pkg::ADDR_CTRL2, k == 1 ? 8'h04 : 8'h0C);
      node.send(8'h00);
      apb(1'b0, ucb_pkg::ADDR_STAT, 8'h00);
      chk("wake flag", k == 2, rd[ucb_pkg::B_WAKEF]);
      chk("wake irq", k == 2, irq);
      apb(1'b1, ucb_pkg::ADDR_STAT, 8'h10);
    end
    clk_off <= 1'b0;
    $display("test wake done");
    apb(1'b1, ucb_pkg::ADDR_SWC, 8'h01);
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'h80);
    r = rnd();
    apb(1'b1, ucb_pkg::ADDR_DATA, r[7:0]);
    wait_st(ucb_pkg::B_TIDLE);
    chk("sw count", 1, node.got_q.size());
    if (node.got_q.size() > 0) chk("sw byte", r[7:0], node.got_q.pop_front());
    apb(1'b1, ucb_pkg::ADDR_CTRL2, 8'hC0);
    @(negedge clk);
    chk("sw both oe", 0, shoe);
    chk("sw tx oe", 0, txoe);
    $display("test single wire done");
    finish_test();
  end
endmodule : tb
